// ---- verilog/tpw_pkg.sv ----
// tpw_pkg: register map, field layouts and reset values of the
// dual timer split / pwm block.
// assumes an ahb-lite slave with 32-bit data, one word per register.
`default_nettype none

package tpw_pkg;

  // register byte offsets
  localparam logic [5:0] OFS_MODE  = 6'h00;
  localparam logic [5:0] OFS_CTRL  = 6'h04;
  localparam logic [5:0] OFS_CTRLB = 6'h08;
  localparam logic [5:0] OFS_CLK   = 6'h0c;
  localparam logic [5:0] OFS_CNT0  = 6'h10;
  localparam logic [5:0] OFS_RLD0  = 6'h14;
  localparam logic [5:0] OFS_CNT1  = 6'h18;
  localparam logic [5:0] OFS_RLD1  = 6'h1c;
  localparam logic [5:0] OFS_STAT  = 6'h20;

  localparam logic [7:0] BYTE_MAX  = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // the two mode bits of one timer
  typedef enum logic [1:0] {
    TPW_LOG   = 2'b00,
    TPW_RLD   = 2'b01,
    TPW_AUTO8 = 2'b10,
    TPW_SPLIT = 2'b11
  } tpw_mode_t;

  typedef struct packed {
    logic      gate;
    logic      ct;
    tpw_mode_t mode;
  } tpw_tmode_t;

  // timer_mode_register layout
  typedef struct packed {
    tpw_tmode_t t1;
    tpw_tmode_t t0;
  } tpw_modereg_t;

  // run bits and overflow flags
  typedef struct packed {
    logic timer1_overflow_flag;
    logic timer0_overflow_flag;
    logic timer1_run;
    logic timer0_run;
  } tpw_ctrl_t;

  // timer_control_b_register layout
  typedef struct packed {
    logic       pwm_enable_timer1;
    logic       pwm_enable_timer0;
    logic [2:0] psc1;
    logic [2:0] psc0;
  } tpw_ctrlb_t;

  // clock_control_register_a layout
  typedef struct packed {
    logic       compat;
    logic       x2_1;
    logic       x2_0;
    logic [3:0] shared_prescale_setting;
  } tpw_clk_t;

  // one timer pin: level and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } tpw_pin_t;

  localparam tpw_modereg_t MODE_RST  = 8'h00;
  localparam tpw_ctrl_t    CTRL_RST  = 4'h0;
  localparam tpw_ctrlb_t   CTRLB_RST = 8'h24;
  localparam tpw_clk_t     CLK_RST   = 7'h00;
  localparam logic [3:0]   PIN_RST   = 4'hf;

endpackage

`default_nettype wire

// ---- verilog/tpw_sync3.sv ----
// tpw_sync3: three-stage synchroniser for asynchronous pin inputs.
// assumes one clock; a new level is taken once stages two and three agree.
`timescale 1ns/10ps
`default_nettype none

module tpw_sync3 #(
  parameter int unsigned      WIDTH   = 4,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;

  // shift chain; first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept a level per bit once the last two stages agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST_VAL;
    end else begin
      q <= (s2_r & s3_r) | (q & (s2_r ^ s3_r));
    end
  end

endmodule // tpw_sync3

`default_nettype wire

// ---- verilog/tpw_timer_pwm.sv ----
// tpw_timer_pwm: two 8-bit-pair timers with split and pwm modes behind
// an ahb-lite register slave.
// assumes hclk is the system clock; pins come from outside and are
// synchronised here; the pin pads combine out and oe_n.
//
// Overview of operation
// - timer 1 in split mode 3 holds its count as if not running
// - timer 0 mode 3: low byte uses timer 0 select, gate, run, pin, flag
// - timer 0 mode 3: high byte counts clocks, timer 1 run and flag
// - timer 0 mode 3: timer 1 keeps its mode, baud tick, no flag
// - timer 0 mode 3: timer 1 stops in its mode 3, runs otherwise
// - split counters overflow every 256 ticks of 1, prescale-plus-one or twice that many clocks
// - fast mode prescales only with double bit; compat always, bit doubles
// - pwm enable makes an 8-bit edge-aligned pwm on the timer pin
// - flags and baud timing keep working in pwm mode
// - gate still halts the counter and waveform in pwm mode, except the mode 3 high byte channel
// - pwm modes 0 and 1: high on wrap to 00h, low on compare match
// - duty writes reach the active compare only on ffh to 00h wrap
// - duty of 00h keeps the pwm output low
// - pwm mode 0: low byte is a logarithmic prescaler of field-plus-one bits
// - pwm mode 1: low byte linear prescaler reloaded from reload low
// - pwm mode 2: 8-bit auto-reload, pin toggles each low overflow
// - timer 1 in pwm mode 3 holds its count
// - pwm mode 3: high byte channel uses timer 1 run, enable, flag
// - pwm mode 3: reload low is low duty, reload high is high duty
// - pwm mode 3: both channels have fixed 256-tick period
// - two mode bits per timer select the four pwm modes
// - active prescaler bits equal field plus one; reset field 100b
// - auto-reload overflow sets flag, reloads low from high byte
// - clearing pwm enable stops driving the pin
`timescale 1ns/10ps
`default_nettype none

module tpw_timer_pwm (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic                  hreadyout,
  output logic                  hresp,
  output logic      [31:0]      hrdata,
  input  wire logic             timer0_pin_in,
  input  wire logic             timer1_pin_in,
  input  wire logic             ext_interrupt0_pin_n,
  input  wire logic             ext_interrupt1_pin_n,
  output var  tpw_pkg::tpw_pin_t timer0_pin,
  output var  tpw_pkg::tpw_pin_t timer1_pin,
  output logic                  timer0_overflow_flag,
  output logic                  timer1_overflow_flag,
  output logic                  timer1_baud_tick
);
  import tpw_pkg::*;

  tpw_modereg_t     mode_r;
  tpw_ctrl_t        ctrl_r;
  tpw_ctrlb_t       ctrlb_r;
  tpw_clk_t         clk_r;
  logic [1:0][7:0]  tl_r;
  logic [1:0][7:0]  th_r;
  logic [1:0][7:0]  rl_r;
  logic [1:0][7:0]  rh_r;
  logic [1:0][7:0]  ocr_r;
  logic [1:0]       pout_r;
  wire  logic [1:0][7:0] tl_nxt;
  wire  logic [1:0][7:0] th_nxt;
  wire  logic [1:0] lo_ovf;
  wire  logic [1:0] hi_ovf;
  logic             wr_pend_r;
  logic [5:0]       wr_addr_r;
  logic [31:0]      rd_nxt;
  logic [3:0]       pin_q;
  logic [3:0]       pin_prev_r;
  logic [3:0]       presc_cnt_r;
  logic [1:0]       half_r;
  logic             baud_r;

  // ---------------- ahb-lite slave ----------------
  wire logic acc = hsel & htrans[1] & hready;

  // zero-wait slave, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // address phase capture for the write data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 6'h00;
    end else begin
      wr_pend_r <= acc & hwrite;
      if (acc) begin
        wr_addr_r <= haddr[5:0];
      end
    end
  end

  wire logic we_mode  = wr_pend_r & (wr_addr_r == OFS_MODE);
  wire logic we_ctrl  = wr_pend_r & (wr_addr_r == OFS_CTRL);
  wire logic we_ctrlb = wr_pend_r & (wr_addr_r == OFS_CTRLB);
  wire logic we_clk   = wr_pend_r & (wr_addr_r == OFS_CLK);
  wire logic [1:0] we_cnt = {wr_pend_r & (wr_addr_r == OFS_CNT1),
                             wr_pend_r & (wr_addr_r == OFS_CNT0)};
  wire logic [1:0] we_rld = {wr_pend_r & (wr_addr_r == OFS_RLD1),
                             wr_pend_r & (wr_addr_r == OFS_RLD0)};

  // read mux, decoded in the address phase
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (haddr[5:0] == OFS_MODE) begin
      rd_nxt[7:0] = mode_r;
    end else if (haddr[5:0] == OFS_CTRL) begin
      rd_nxt[3:0] = ctrl_r;
    end else if (haddr[5:0] == OFS_CTRLB) begin
      rd_nxt[7:0] = ctrlb_r;
    end else if (haddr[5:0] == OFS_CLK) begin
      rd_nxt[6:0] = clk_r;
    end else if (haddr[5:0] == OFS_CNT0) begin
      rd_nxt[15:0] = {th_r[0], tl_r[0]};
    end else if (haddr[5:0] == OFS_RLD0) begin
      rd_nxt[15:0] = {rh_r[0], rl_r[0]};
    end else if (haddr[5:0] == OFS_CNT1) begin
      rd_nxt[15:0] = {th_r[1], tl_r[1]};
    end else if (haddr[5:0] == OFS_RLD1) begin
      rd_nxt[15:0] = {rh_r[1], rl_r[1]};
    end else if (haddr[5:0] == OFS_STAT) begin
      rd_nxt[23:0] = {ocr_r[1], ocr_r[0], 6'h00, pout_r};
    end
  end

  // read data stands during the data phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      hrdata <= rd_nxt;
    end
  end

  // configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r  <= MODE_RST;
      ctrlb_r <= CTRLB_RST;
      clk_r   <= CLK_RST;
    end else begin
      if (we_mode) begin
        mode_r <= tpw_modereg_t'(hwdata[7:0]);
      end
      if (we_ctrlb) begin
        ctrlb_r <= tpw_ctrlb_t'(hwdata[7:0]);
      end
      if (we_clk) begin
        clk_r <= tpw_clk_t'(hwdata[6:0]);
      end
    end
  end

  // duty and reload holding registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rl_r <= '0;
      rh_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (we_rld[i]) begin
          rl_r[i] <= hwdata[7:0];
          rh_r[i] <= hwdata[15:8];
        end
      end
    end
  end

  // ---------------- pins ----------------
  tpw_sync3 #(
    .WIDTH   (4),
    .RST_VAL (PIN_RST)
  ) u_sync (
    .clk   (hclk),
    .rst_n (hresetn),
    .d     ({ext_interrupt1_pin_n, ext_interrupt0_pin_n,
             timer1_pin_in, timer0_pin_in}),
    .q     (pin_q)
  );

  // previous level for falling edge count on the timer pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_prev_r <= PIN_RST;
    end else begin
      pin_prev_r <= pin_q;
    end
  end

  wire logic [1:0] ext_fall = pin_prev_r[1:0] & ~pin_q[1:0];
  wire logic [1:0] int_lvl  = pin_q[3:2];

  // ---------------- shared prescaler ----------------
  wire logic presc_tick = (presc_cnt_r == clk_r.shared_prescale_setting);

  // divide by setting plus one, and a half-rate toggle per timer
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      presc_cnt_r <= 4'h0;
      half_r      <= 2'b00;
    end else begin
      presc_cnt_r <= presc_tick ? 4'h0 : presc_cnt_r + 4'h1;
      if (presc_tick) begin
        half_r <= ~half_r;
      end
    end
  end

  // ---------------- count enables ----------------
  wire logic [1:0]      x2      = {clk_r.x2_1, clk_r.x2_0};
  wire logic [1:0]      pwm_en  = {ctrlb_r.pwm_enable_timer1,
                                   ctrlb_r.pwm_enable_timer0};
  wire tpw_tmode_t      tm [2];
  wire logic [1:0][2:0] psc     = {ctrlb_r.psc1, ctrlb_r.psc0};
  wire logic            split0  = (mode_r.t0.mode == TPW_SPLIT);
  wire logic [1:0]      tick;
  wire logic [1:0]      run_ok;
  wire logic [1:0]      ev;
  wire logic [1:0]      evh;

  assign tm[0] = mode_r.t0;
  assign tm[1] = mode_r.t1;

  // timer 0 low side: own run bit and gate
  assign run_ok[0] = ctrl_r.timer0_run
                   & (~tm[0].gate | int_lvl[0]);
  // timer 1: frozen in its mode 3; run bit lent to the split high byte
  assign run_ok[1] = (tm[1].mode != TPW_SPLIT)
                   & (split0 ? 1'b1
                      : ctrl_r.timer1_run & (~tm[1].gate | int_lvl[1]));
  // split high byte: clock ticks only, timer 1 run bit
  assign evh[0] = split0 & ctrl_r.timer1_run & tick[0];
  assign evh[1] = 1'b0;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_tmr
      logic [7:0] mask;
      logic [7:0] low_byte_counter;
      logic [7:0] high_byte_counter;
      logic       lo;
      logic       hi;

      // prescaler gating per timer
      assign tick[gi] = ~(clk_r.compat | x2[gi])
                      | (presc_tick & (~(clk_r.compat & x2[gi]) | half_r[gi]));
      // pwm forces the timer function
      assign ev[gi] = run_ok[gi]
                    & ((tm[gi].ct & ~pwm_en[gi]) ? ext_fall[gi] : tick[gi]);

      // next count per mode
      always_comb begin
        mask = 8'((16'h0002 << psc[gi]) - 16'h0001);
        low_byte_counter  = tl_r[gi];
        high_byte_counter  = th_r[gi];
        lo   = 1'b0;
        hi   = 1'b0;
        case (tm[gi].mode)
          TPW_LOG: begin
            if (ev[gi]) begin
              if ((tl_r[gi] & mask) == mask) begin
                low_byte_counter = BYTE_ZERO;
                high_byte_counter = th_r[gi] + 8'h01;
                hi  = (th_r[gi] == BYTE_MAX);
              end else begin
                low_byte_counter = tl_r[gi] + 8'h01;
              end
            end
          end
          TPW_RLD: begin
            if (ev[gi] && pwm_en[gi]) begin
              if (tl_r[gi] == BYTE_MAX) begin
                low_byte_counter = rl_r[gi];
                high_byte_counter = th_r[gi] + 8'h01;
                hi  = (th_r[gi] == BYTE_MAX);
              end else begin
                low_byte_counter = tl_r[gi] + 8'h01;
              end
            end else if (ev[gi]) begin
              if ({th_r[gi], tl_r[gi]} == 16'hffff) begin
                {high_byte_counter, low_byte_counter} = {rh_r[gi], rl_r[gi]};
                hi         = 1'b1;
              end else begin
                {high_byte_counter, low_byte_counter} = {th_r[gi], tl_r[gi]} + 16'h0001;
              end
            end
          end
          TPW_AUTO8: begin
            if (ev[gi]) begin
              if (tl_r[gi] == BYTE_MAX) begin
                low_byte_counter = th_r[gi];
                lo  = 1'b1;
              end else begin
                low_byte_counter = tl_r[gi] + 8'h01;
              end
            end
          end
          TPW_SPLIT: begin
            if (ev[gi]) begin
              low_byte_counter = tl_r[gi] + 8'h01;
              lo  = (tl_r[gi] == BYTE_MAX);
            end
            if (evh[gi]) begin
              high_byte_counter = th_r[gi] + 8'h01;
              hi  = (th_r[gi] == BYTE_MAX);
            end
          end
        endcase
      end

      assign tl_nxt[gi] = low_byte_counter;
      assign th_nxt[gi] = high_byte_counter;
      assign lo_ovf[gi] = lo;
      assign hi_ovf[gi] = hi;
    end
  endgenerate

  // counter registers; a software write wins over counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tl_r <= '0;
      th_r <= '0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (we_cnt[i]) begin
          tl_r[i] <= hwdata[7:0];
          th_r[i] <= hwdata[15:8];
        end else begin
          tl_r[i] <= tl_nxt[i];
          th_r[i] <= th_nxt[i];
        end
      end
    end
  end

  // ---------------- run bits and flags ----------------
  wire logic set0 = split0 ? lo_ovf[0] : (lo_ovf[0] | hi_ovf[0]);
  wire logic set1 = split0 ? hi_ovf[0]
                           : (lo_ovf[1] | hi_ovf[1]);

  // write one to clear a flag; a same-cycle overflow keeps it set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= CTRL_RST;
    end else begin
      if (we_ctrl) begin
        ctrl_r.timer0_run <= hwdata[0];
        ctrl_r.timer1_run <= hwdata[1];
      end
      ctrl_r.timer0_overflow_flag <= set0 | (ctrl_r.timer0_overflow_flag
                                            & ~(we_ctrl & hwdata[2]));
      ctrl_r.timer1_overflow_flag <= set1 | (ctrl_r.timer1_overflow_flag
                                            & ~(we_ctrl & hwdata[3]));
    end
  end

  // timer 1 overflow pulse for the uart, even while split
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_r <= 1'b0;
    end else begin
      baud_r <= lo_ovf[1] | hi_ovf[1];
    end
  end

  // ---------------- pwm channels ----------------
  tpw_pin_t pin_w [2];

  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      logic       sp_lo;
      logic       src;
      logic       wrap;
      logic       adv;
      logic [7:0] val;
      logic [7:0] duty;
      logic       tog;
      logic       oe_n_r;

      // channel 0 uses the low byte while split, channel 1 the high byte
      assign sp_lo = (gi == 0) & split0;
      assign src   = (gi == 1) & ~split0;
      assign wrap  = sp_lo ? lo_ovf[0] : hi_ovf[src];
      assign val   = sp_lo ? tl_nxt[0] : th_nxt[src];
      assign adv   = sp_lo ? (tl_nxt[0] != tl_r[0]) : (th_nxt[src] != th_r[src]);
      assign duty  = sp_lo ? rl_r[0] : rh_r[src];
      assign tog   = ~split0 & (tm[gi].mode == TPW_AUTO8) & lo_ovf[gi];

      // waveform; holds its level while the counter stands
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pout_r[gi] <= 1'b0;
          ocr_r[gi]  <= BYTE_ZERO;
        end else if (pwm_en[gi]) begin
          if (tog) begin
            pout_r[gi] <= ~pout_r[gi];
          end else if (wrap) begin
            ocr_r[gi]  <= duty;
            pout_r[gi] <= (duty != BYTE_ZERO);
          end else if (adv && (val == ocr_r[gi])) begin
            pout_r[gi] <= 1'b0;
          end
        end
      end

      // drive the pin only while pwm is enabled
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          oe_n_r <= 1'b1;
        end else begin
          oe_n_r <= ~pwm_en[gi];
        end
      end

      assign pin_w[gi] = '{out: pout_r[gi], oe_n: oe_n_r};
    end
  endgenerate

  // outputs straight from flops
  assign timer0_pin           = pin_w[0];
  assign timer1_pin           = pin_w[1];
  assign timer0_overflow_flag = ctrl_r.timer0_overflow_flag;
  assign timer1_overflow_flag = ctrl_r.timer1_overflow_flag;
  assign timer1_baud_tick     = baud_r;

endmodule // tpw_timer_pwm

`default_nettype wire

// ---- dv/tpw_timer_pwm_monitor.sv ----
// tpw_timer_pwm_monitor: bus and pin assertions for the timer/pwm block.
// assumes one ahb-lite master with hready tied to hreadyout.
`timescale 1ns/10ps
`default_nettype none

module tpw_timer_pwm_monitor (
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [31:0]       hwdata,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire logic [31:0]       hrdata,
  input wire tpw_pkg::tpw_pin_t timer0_pin,
  input wire tpw_pkg::tpw_pin_t timer1_pin,
  input wire logic              timer0_overflow_flag,
  input wire logic              timer1_overflow_flag
);
  import tpw_pkg::*;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  logic       acc;
  logic       rd_acc;
  logic       ctrl_dp;
  logic       dp_wr_r;
  logic [5:0] dp_a_r;
  logic [1:0] run_r;
  logic [1:0] en_r;
  logic [2:0] h0_r;
  logic [2:0] h1_r;

  // accepted transfers and a write data phase to the control word
  assign acc = hsel & htrans[1] & hready;
  assign rd_acc = acc & !hwrite;
  assign ctrl_dp = dp_wr_r && (dp_a_r == OFS_CTRL);

  // shadow run and pwm enable bits, keep a short run history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_a_r  <= '0;
      run_r   <= '0;
      en_r    <= '0;
      h0_r    <= '0;
      h1_r    <= '0;
    end else begin
      dp_wr_r <= acc & hwrite;
      dp_a_r  <= haddr[5:0];
      h0_r    <= {h0_r[1:0], run_r[0]};
      h1_r    <= {h1_r[1:0], run_r[1]};
      if (ctrl_dp) begin
        run_r <= hwdata[1:0];
      end
      if (dp_wr_r && dp_a_r == OFS_CTRLB) begin
        en_r <= hwdata[7:6];
      end
    end
  end

  ready_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  rdata_hold_a: assert property (!$past(rd_acc) |-> $stable(hrdata))
    else $error("read data moved without a read");
  flag0_clear_a: assert property ($fell(timer0_overflow_flag) |-> $past(ctrl_dp))
    else $error("flag 0 dropped without a control write");
  flag1_clear_a: assert property ($fell(timer1_overflow_flag) |-> $past(ctrl_dp))
    else $error("flag 1 dropped without a control write");
  flag0_run_a: assert property ($rose(timer0_overflow_flag) |-> |h0_r)
    else $error("flag 0 set while timer 0 stopped");
  flag1_run_a: assert property ($rose(timer1_overflow_flag) |-> |h1_r)
    else $error("flag 1 set while its run bit clear");
  pin0_oe_a: assert property (timer0_pin.oe_n == !$past(en_r[0]))
    else $error("pin 0 enable does not follow pwm enable");
  pin1_oe_a: assert property (timer1_pin.oe_n == !$past(en_r[1]))
    else $error("pin 1 enable does not follow pwm enable");
  pin0_hold_a: assert property (!$past(en_r[0]) && !$past(en_r[0], 2)
    |-> $stable(timer0_pin.out)) else $error("pin 0 moved while pwm off");
  pin1_hold_a: assert property (!$past(en_r[1]) && !$past(en_r[1], 2)
    |-> $stable(timer1_pin.out)) else $error("pin 1 moved while pwm off");
endmodule // tpw_timer_pwm_monitor

bind tpw_timer_pwm tpw_timer_pwm_monitor u_mon (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .hrdata(hrdata), .timer0_pin(timer0_pin), .timer1_pin(timer1_pin),
  .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag)
);

`default_nettype wire

// ---- dv/tb_tpw_timer_pwm.sv ----
// tb_tpw_timer_pwm: self-checking bench for the timer/pwm block.
// assumes the block answers every transfer at once; timer pins only observed, interrupt 0 pin driven as gate.
`timescale 1ns/10ps
`default_nettype none

module tb_tpw_timer_pwm;
  import tpw_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b1;
  logic [31:0] haddr = '0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic        ext_interrupt0_pin_n = 1'b1;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  tpw_pin_t    timer0_pin;
  tpw_pin_t    timer1_pin;
  logic        timer0_overflow_flag;
  logic        timer1_overflow_flag;
  logic        timer1_baud_tick;
  int          errors = 0;
  int          n_compared = 0;
  logic [31:0] clk_tab [4] = '{32'h03, 32'h13, 32'h43, 32'h53};
  int          per_tab [4] = '{32, 128, 128, 256};

  assign hready = hreadyout;

  tpw_timer_pwm DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .timer0_pin_in(1'b1),
    .timer1_pin_in(1'b1), .ext_interrupt0_pin_n(ext_interrupt0_pin_n),
    .ext_interrupt1_pin_n(1'b1), .timer0_pin(timer0_pin), .timer1_pin(timer1_pin),
    .timer0_overflow_flag(timer0_overflow_flag),
    .timer1_overflow_flag(timer1_overflow_flag), .timer1_baud_tick(timer1_baud_tick)
  );

  // 100 mhz clock
  always #5 hclk = ~hclk;

  task automatic test_done();
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, g, e);
    end
  endtask

  // one single transfer: address phase, then data phase
  task automatic xfer(input logic w, input logic [5:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge hclk);
    haddr <= {26'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rdc(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    logic [31:0] q;
    xfer(1'b0, a, '0, q);
    chk(q & m, e);
  endtask

  function automatic logic pout(input logic s);
    return s ? timer1_pin.out : timer0_pin.out;
  endfunction

  // wait, bounded, until a pin shows a level, counting clocks
  task automatic wt(input logic s, input logic v, inout int c);
    int k;
    k = 0;
    while (pout(s) !== v && k < 9000) begin
      @(negedge hclk);
      c++;
      k++;
    end
  endtask

  // high time and period of a pin, from one rising edge on
  task automatic meas(input logic s, input int hi, input int per);
    int c;
    c = 0;
    wt(s, 1'b0, c);
    wt(s, 1'b1, c);
    c = 0;
    wt(s, 1'b0, c);
    chk(c, hi);
    wt(s, 1'b1, c);
    chk(c, per);
  endtask

  // watchdog
  initial begin
    repeat (100000) @(posedge hclk);
    errors++;
    test_done();
  end

  initial begin
    logic [31:0] v;
    logic        o;
    int          c;
    int          nb;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    rdc(OFS_MODE, 32'h0);
    rdc(OFS_CTRLB, 32'h24);
    rdc(OFS_CLK, 32'h0);
    wr(6'h3c, 32'hffffffff);
    rdc(6'h3c, 32'h0);
    // pwm mode 0, one prescaler bit: period 512 clocks, duty 0x80
    wr(OFS_RLD0, 32'h8000);
    wr(OFS_CTRLB, 32'h40);
    wr(OFS_CTRL, 32'h1);
    meas(1'b0, 256, 512);
    rdc(OFS_STAT, 32'h8000, 32'hff00);
    rdc(OFS_CTRL, 32'h5);
    chk(timer0_pin.oe_n, 1'b0);
    // zero duty only lands at the next wrap, then the pin stays low
    wr(OFS_RLD0, 32'h0);
    rdc(OFS_STAT, 32'h8000, 32'hff00);
    c = 0;
    wt(1'b0, 1'b0, c);
    c = 0;
    wt(1'b0, 1'b1, c);
    chk(c, 9000);
    // pwm mode 1: reload 0xfc gives four ticks a step
    wr(OFS_MODE, 32'h1);
    wr(OFS_RLD0, 32'h40fc);
    meas(1'b0, 256, 1024);
    // pwm mode 2 square wave at each tick rate setting
    wr(OFS_CNT0, 32'hf000);
    wr(OFS_MODE, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CLK, clk_tab[i]);
      meas(1'b0, per_tab[i] / 2, per_tab[i]);
    end
    rdc(OFS_CNT0, 32'hf000, 32'hff00);
    // gate low halts count and pin
    wr(OFS_CLK, 32'h0);
    wr(OFS_MODE, 32'ha);
    ext_interrupt0_pin_n <= 1'b0;
    repeat (8) @(posedge hclk);
    xfer(1'b0, OFS_CNT0, '0, v);
    o = timer0_pin.out;
    repeat (300) @(posedge hclk);
    rdc(OFS_CNT0, v);
    chk(timer0_pin.out, o);
    ext_interrupt0_pin_n <= 1'b1;
    meas(1'b0, 16, 32);
    // split pwm: both channels 256 ticks, duties from the two reloads
    wr(OFS_RLD0, 32'hc040);
    wr(OFS_CTRLB, 32'hc0);
    wr(OFS_MODE, 32'h3);
    wr(OFS_CTRL, 32'h3);
    meas(1'b0, 64, 256);
    meas(1'b1, 192, 256);
    // split timer: high byte sets flag 1, low byte idle without its run bit
    wr(OFS_CTRLB, 32'h24);
    wr(OFS_CTRL, 32'h0e);
    // clear flag 0 again once timer 0 stands, in case its overflow met the first clear
    wr(OFS_CTRL, 32'h06);
    c = 0;
    do begin
      @(negedge hclk);
      c++;
    end while (timer1_overflow_flag !== 1'b1 && c < 400);
    chk(c < 260, 1'b1);
    chk(timer0_overflow_flag, 1'b0);
    // timer 1 keeps running for baud, without its flag
    wr(OFS_CTRL, 32'h08);
    nb = 0;
    repeat (9000) begin
      @(negedge hclk);
      nb += int'(timer1_baud_tick === 1'b1);
    end
    chk(nb > 0 && nb < 3, 1'b1);
    chk(timer1_overflow_flag, 1'b0);
    wr(OFS_MODE, 32'h33);
    xfer(1'b0, OFS_CNT1, '0, v);
    repeat (50) @(posedge hclk);
    rdc(OFS_CNT1, v);
    test_done();
  end
endmodule // tb_tpw_timer_pwm

`default_nettype wire
